// ---- include/egress_rate_pkg.sv ----
// constants for the per-port egress rate ceiling registers and shapers
package egress_rate_pkg;

    // clock and shaper time base
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned TICK_NS         = 1000;
    localparam int unsigned TICK_CYCLES     = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TICK_CNT_W      = 7;

    // topology
    localparam int unsigned NUM_PORTS       = 3;
    localparam int unsigned NUM_QUEUES      = 4;
    localparam int unsigned NUM_RATE_REGS   = 6;

    // register offsets on the management register space
    localparam logic [7:0]  PORT1_EGRESS_RATE_LO = 8'h18;
    localparam logic [7:0]  PORT1_EGRESS_RATE_HI = 8'h19;
    localparam logic [7:0]  PORT2_EGRESS_RATE_LO = 8'h28;
    localparam logic [7:0]  PORT2_EGRESS_RATE_HI = 8'h29;
    localparam logic [7:0]  PORT3_EGRESS_RATE_LO = 8'h38;
    localparam logic [7:0]  PORT3_EGRESS_RATE_HI = 8'h39;
    localparam logic [7:0]  RATE_REG_ADDR [NUM_RATE_REGS] = '{
        PORT1_EGRESS_RATE_LO, PORT1_EGRESS_RATE_HI,
        PORT2_EGRESS_RATE_LO, PORT2_EGRESS_RATE_HI,
        PORT3_EGRESS_RATE_LO, PORT3_EGRESS_RATE_HI};

    // field layout: lo register holds queues 0/1, hi register holds queues 2/3
    localparam int unsigned CODE_W          = 4;
    localparam int unsigned LOW_NIB_LSB     = 0;
    localparam int unsigned HIGH_NIB_LSB    = 4;
    localparam logic [7:0]  RATE_REG_RESET  = 8'h00;
    localparam logic [7:0]  UNMAPPED_RDATA  = 8'h00;

    // rate codes
    localparam logic [3:0]  CODE_UNLIMITED  = 4'h0;
    localparam logic [3:0]  CODE_MAX_TEN_MEG = 4'h8;

    // credit added per tick, in millibits per microsecond (equals kbps)
    localparam logic [16:0] RATE_TABLE [16] = '{
        17'h00000, 17'h00040, 17'h00080, 17'h00100,
        17'h00200, 17'h003e8, 17'h007d0, 17'h00fa0,
        17'h01f40, 17'h03e80, 17'h07d00, 17'h0bb80,
        17'h0fa00, 17'h11940, 17'h13880, 17'h157c0};

    // bucket sizing
    localparam int unsigned LEN_W           = 11;
    localparam int unsigned MBITS_PER_BYTE  = 8000;
    localparam int unsigned MAX_FRAME_BYTES = 1522;
    localparam int unsigned BURST_CAP       = MAX_FRAME_BYTES * MBITS_PER_BYTE;
    localparam int unsigned CREDIT_W        = 26;

endpackage : egress_rate_pkg

// ---- include/shaper_if.sv ----
// link between the rate register bank and one queue's credit bucket
interface shaper_if;
    import egress_rate_pkg::*;

    logic [CODE_W-1:0] code;      // effective code, already overridden
    logic              tick;      // one pulse per microsecond
    logic              start;     // frame start on this queue
    logic [LEN_W-1:0]  len;       // frame length in bytes
    logic              eligible;  // queue may start a frame

    modport ctrl   (output code, output tick, output start, output len, input eligible);
    modport bucket (input code, input tick, input start, input len, output eligible);
endinterface : shaper_if

// ---- logic/egress_rate_limit.sv ----
// per-port egress rate ceiling registers and queue shapers for three switch ports
// Functional notes
// - each queue kept under its selected ceiling
// - first register: prio1 bits 7-4, prio0 3-0
// - second register: prio3 upper, prio2 lower nibble
// - registers at 0x18/19, 0x28/29, 0x38/39
// - code zero unlimited, all fields reset zero
// - codes 1-7: 64Kbps doubling to 4Mbps
// - codes 8-11: 8, 16, 32, 48 Mbps
// - code 12 is 64, 13 is 72 Mbps
// - at 10 Mbps, ceilings above ten unlimited
// - single queue mode: only priority 0 limits
module egress_rate_limit
    import egress_rate_pkg::*;
(
    // clock, reset, enable
    input  wire logic                                 ref_clk_i,
    input  wire logic                                 arst_n_i,
    input  wire logic                                 ce_i,
    // management register access
    input  wire logic                                 reg_wr_i,
    input  wire logic                                 reg_rd_i,
    input  wire logic [7:0]                           reg_addr_i,
    input  wire logic [7:0]                           reg_wdata_i,
    output logic      [7:0]                           reg_rdata_o,
    // port mode
    input  wire logic [NUM_PORTS-1:0]                 ten_meg_twisted_pair_speed_i,
    input  wire logic                                 multi_queue_en_i,
    // scheduler side
    input  wire logic [NUM_PORTS-1:0]                 tx_busy_i,
    input  wire logic [NUM_PORTS-1:0]                 frame_start_i,
    input  wire logic [NUM_PORTS-1:0][1:0]            frame_queue_i,
    input  wire logic [NUM_PORTS-1:0][LEN_W-1:0]      frame_len_i,
    output logic      [NUM_PORTS-1:0][NUM_QUEUES-1:0] queue_eligible_o
);

    logic [7:0]            rate_reg_r [NUM_RATE_REGS];
    logic [7:0]            rdata_r;
    logic [7:0]            rdata_nxt;
    logic [TICK_CNT_W-1:0] tick_cnt_r;
    logic                  tick;
    logic [CODE_W-1:0]     raw_code  [NUM_PORTS][NUM_QUEUES];
    logic [CODE_W-1:0]     eff_code  [NUM_PORTS][NUM_QUEUES];
    logic [CODE_W-1:0]     code_r    [NUM_PORTS][NUM_QUEUES];

    // register writes; each offset decoded against its own address
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < NUM_RATE_REGS; i++) begin
                rate_reg_r[i] <= RATE_REG_RESET;
            end
        end else if (ce_i && reg_wr_i) begin
            for (int i = 0; i < NUM_RATE_REGS; i++) begin
                if (reg_addr_i == RATE_REG_ADDR[i]) begin
                    rate_reg_r[i] <= reg_wdata_i;
                end
            end
        end
    end

    // read mux; offsets outside this bank read as zero
    always_comb begin
        rdata_nxt = UNMAPPED_RDATA;
        for (int i = 0; i < NUM_RATE_REGS; i++) begin
            if (reg_addr_i == RATE_REG_ADDR[i]) begin
                rdata_nxt = rate_reg_r[i];
            end
        end
    end

    // read data held until the next read
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_r <= UNMAPPED_RDATA;
        end else if (ce_i && reg_rd_i) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;

    // one microsecond time base shared by all twelve buckets
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_cnt_r <= '0;
        end else if (ce_i) begin
            if (tick) begin
                tick_cnt_r <= '0;
            end else begin
                tick_cnt_r <= tick_cnt_r + 1'b1;
            end
        end
    end

    assign tick = (tick_cnt_r == TICK_CNT_W'(TICK_CYCLES - 1));

    // field unpack, then speed and queue-mode overrides
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            raw_code[p][0] = rate_reg_r[2*p][LOW_NIB_LSB +: CODE_W];
            raw_code[p][1] = rate_reg_r[2*p][HIGH_NIB_LSB +: CODE_W];
            raw_code[p][2] = rate_reg_r[2*p+1][LOW_NIB_LSB +: CODE_W];
            raw_code[p][3] = rate_reg_r[2*p+1][HIGH_NIB_LSB +: CODE_W];
            for (int q = 0; q < NUM_QUEUES; q++) begin
                eff_code[p][q] = raw_code[p][q];
                if (ten_meg_twisted_pair_speed_i[p] && raw_code[p][q] > CODE_MAX_TEN_MEG) begin
                    eff_code[p][q] = CODE_UNLIMITED;
                end
                if (!multi_queue_en_i && q != 0) begin
                    eff_code[p][q] = CODE_UNLIMITED;
                end
            end
        end
    end

    // codes move to the shaper only between frames, never mid-frame
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                for (int q = 0; q < NUM_QUEUES; q++) begin
                    code_r[p][q] <= CODE_UNLIMITED;
                end
            end
        end else if (ce_i) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (!tx_busy_i[p]) begin
                    for (int q = 0; q < NUM_QUEUES; q++) begin
                        code_r[p][q] <= eff_code[p][q];
                    end
                end
            end
        end
    end

    // one bucket per port and queue
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        for (genvar q = 0; q < NUM_QUEUES; q++) begin : g_queue
            shaper_if sif ();

            assign sif.code  = code_r[p][q];
            assign sif.tick  = tick;
            assign sif.len   = frame_len_i[p];
            // single queue mode books every frame to the priority 0 bucket
            assign sif.start = frame_start_i[p]
                && (multi_queue_en_i ? (frame_queue_i[p] == 2'(q)) : (q == 0));
            assign queue_eligible_o[p][q] = sif.eligible;

            rate_bucket u_bucket (
                .ref_clk_i (ref_clk_i),
                .arst_n_i  (arst_n_i),
                .ce_i      (ce_i),
                .sif       (sif)
            );
        end
    end

    // checks
    a_write_readback: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && reg_wr_i && reg_addr_i == PORT1_EGRESS_RATE_HI ##1 !reg_wr_i
            ##1 ce_i && reg_rd_i && !reg_wr_i && reg_addr_i == PORT1_EGRESS_RATE_HI
            |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("rate register readback mismatch");

    a_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && reg_rd_i && reg_addr_i == 8'h1a |=> reg_rdata_o == UNMAPPED_RDATA)
        else $error("unmapped offset read not zero");

    a_nibble_map: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        raw_code[0][1] == rate_reg_r[0][7:4] && raw_code[2][0] == rate_reg_r[4][3:0])
        else $error("low register nibbles misplaced");

    a_ten_meg_cut: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && !tx_busy_i[1] && ten_meg_twisted_pair_speed_i[1]
            && multi_queue_en_i && raw_code[1][0] > CODE_MAX_TEN_MEG
            |=> code_r[1][0] == CODE_UNLIMITED)
        else $error("10 Mbps override missing");

    a_single_queue: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && !multi_queue_en_i && !tx_busy_i[0]
            |=> code_r[0][2] == CODE_UNLIMITED && code_r[0][0] == $past(eff_code[0][0]))
        else $error("single queue mode codes wrong");

    a_busy_hold: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        tx_busy_i[2] |=> code_r[2][0] == $past(code_r[2][0]))
        else $error("code changed during a frame");

    a_tick_period: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && tick |=> !tick)
        else $error("tick not a single pulse");

    c_write_seen: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && reg_wr_i && reg_addr_i == PORT1_EGRESS_RATE_LO && reg_wdata_i != 8'h00);

    c_frame_throttled: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        frame_start_i[0] ##1 !(&queue_eligible_o[0]));

    c_ten_meg: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ten_meg_twisted_pair_speed_i[2] && raw_code[2][0] > CODE_MAX_TEN_MEG);

endmodule : egress_rate_limit

// ---- logic/rate_bucket.sv ----
// credit bucket that holds one egress queue under its rate ceiling
module rate_bucket
    import egress_rate_pkg::*;
(
    // clock and reset
    input  wire logic  ref_clk_i,
    input  wire logic  arst_n_i,
    input  wire logic  ce_i,
    // shaper link
    shaper_if.bucket   sif
);

    localparam logic signed [CREDIT_W:0] CAP_S = $signed((CREDIT_W+1)'(BURST_CAP));

    logic signed [CREDIT_W-1:0] credit_r;
    logic signed [CREDIT_W-1:0] credit_nxt;
    logic signed [CREDIT_W:0]   sum;
    logic                       eligible_r;

    // refill on tick, debit full frame at start; a frame may overdraw
    always_comb begin
        sum = {credit_r[CREDIT_W-1], credit_r};
        if (sif.tick) begin
            sum = sum + $signed((CREDIT_W+1)'(RATE_TABLE[sif.code]));
        end
        if (sif.start) begin
            sum = sum - $signed((CREDIT_W+1)'(sif.len * MBITS_PER_BYTE));
        end
        if (sif.code == CODE_UNLIMITED || sum > CAP_S) begin
            credit_nxt = CAP_S[CREDIT_W-1:0];
        end else begin
            credit_nxt = sum[CREDIT_W-1:0];
        end
    end

    // credit store; full bucket after reset so the first frame goes at once
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            credit_r <= CAP_S[CREDIT_W-1:0];
        end else if (ce_i) begin
            credit_r <= credit_nxt;
        end
    end

    // eligibility registered; debt blocks the queue until refilled
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            eligible_r <= 1'b1;
        end else if (ce_i) begin
            eligible_r <= (sif.code == CODE_UNLIMITED) || !credit_nxt[CREDIT_W-1];
        end
    end

    assign sif.eligible = eligible_r;

    a_unlimited_open: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && sif.code == CODE_UNLIMITED |=> eligible_r)
        else $error("unlimited queue not eligible");

    a_credit_capped: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        credit_r <= $signed(CAP_S[CREDIT_W-1:0]))
        else $error("credit above burst cap");

    a_debt_blocks: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && sif.code != CODE_UNLIMITED && credit_nxt[CREDIT_W-1] |=> !eligible_r)
        else $error("queue eligible while in debt");

    a_frame_debit: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && sif.start && !sif.tick && sif.len != '0
            && sif.code != CODE_UNLIMITED |=> credit_r < $past(credit_r))
        else $error("frame start did not debit credit");

    c_debt_seen: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !eligible_r ##[1:1000] eligible_r);

endmodule : rate_bucket

// ---- tb/egress_rate_limit_tb_top.sv ----
// self-checking bench for the per-port egress rate ceiling registers and shapers
module egress_rate_limit_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import egress_rate_pkg::*;

    logic                                 ref_clk_i = 1'b0;
    logic                                 arst_n_i = 1'b0;
    logic                                 ce_i = 1'b1;
    logic                                 reg_wr_i = 1'b0;
    logic                                 reg_rd_i = 1'b0;
    logic [7:0]                           reg_addr_i = 8'h00;
    logic [7:0]                           reg_wdata_i = 8'h00;
    logic [7:0]                           reg_rdata_o;
    logic [NUM_PORTS-1:0]                 ten_meg_twisted_pair_speed_i = '0;
    logic                                 multi_queue_en_i = 1'b1;
    logic [NUM_PORTS-1:0]                 tx_busy_i = '0;
    logic [NUM_PORTS-1:0]                 frame_start_i = '0;
    logic [NUM_PORTS-1:0][1:0]            frame_queue_i = '0;
    logic [NUM_PORTS-1:0][LEN_W-1:0]      frame_len_i = '0;
    logic [NUM_PORTS-1:0][NUM_QUEUES-1:0] queue_eligible_o;
    int                                   num_errors = 0;
    int                                   checks_done = 0;
    int                                   cycles = 0;

    egress_rate_limit u_egress_rate_limit (
        .ref_clk_i                    (ref_clk_i),
        .arst_n_i                     (arst_n_i),
        .ce_i                         (ce_i),
        .reg_wr_i                     (reg_wr_i),
        .reg_rd_i                     (reg_rd_i),
        .reg_addr_i                   (reg_addr_i),
        .reg_wdata_i                  (reg_wdata_i),
        .reg_rdata_o                  (reg_rdata_o),
        .ten_meg_twisted_pair_speed_i (ten_meg_twisted_pair_speed_i),
        .multi_queue_en_i             (multi_queue_en_i),
        .tx_busy_i                    (tx_busy_i),
        .frame_start_i                (frame_start_i),
        .frame_queue_i                (frame_queue_i),
        .frame_len_i                  (frame_len_i),
        .queue_eligible_o             (queue_eligible_o)
    );

    // free-running 100 MHz clock
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // hang guard: the whole run needs well under this many cycles
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // inputs always move 1 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        cyc(1);
        reg_wr_i = 1'b0;
        cyc(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        cyc(1);
        reg_rd_i = 1'b0;
        chk("rdata", 16'(reg_rdata_o), 16'(exp));
        cyc(1);
    endtask : rd

    // one frame start pulse, then a quiet cycle so the strobe is never reassigned at once
    task automatic start(input int p, input int q, input logic [LEN_W-1:0] len);
        frame_start_i[p] = 1'b1;
        frame_queue_i[p] = 2'(q);
        frame_len_i[p] = len;
        cyc(1);
        frame_start_i[p] = 1'b0;
        cyc(1);
    endtask : start

    // a full-size frame empties a full bucket, a short one pushes it 512000 below zero
    task automatic drain(input int p, input int q);
        start(p, q, 11'd1522);
        start(p, q, 11'd64);
    endtask : drain

    // k refills are needed; one may slip in between the two frames of drain
    task automatic recover(input int p, input int q, input int k);
        int n;
        n = 0;
        chk("blocked", 16'(queue_eligible_o[p][q]), 16'h0000);
        while (queue_eligible_o[p][q] !== 1'b1 && n < 1200) begin
            cyc(1);
            n++;
        end
        chk("refill", 16'(n >= (k - 2) * 100 && n <= k * 100 + 5), 16'h0001);
    endtask : recover

    task automatic t_regs();
        chk("eligible", 16'(queue_eligible_o), 16'h0fff);
        for (int i = 0; i < NUM_RATE_REGS; i++) begin
            rd(RATE_REG_ADDR[i], 8'h00);
            wr(RATE_REG_ADDR[i], {4'(i + 1), 4'(8 - i)});
        end
        for (int i = 0; i < NUM_RATE_REGS; i++) begin
            rd(RATE_REG_ADDR[i], {4'(i + 1), 4'(8 - i)});
            wr(RATE_REG_ADDR[i], 8'h00);
        end
        wr(8'h1a, 8'h77);
        rd(8'h1a, 8'h00);
        ce_i = 1'b0;
        wr(8'h18, 8'hff);
        ce_i = 1'b1;
        rd(8'h18, 8'h00);
        $display("register test done");
    endtask : t_regs

    // port 0: q1 72, q2 80, q3 88 Mbps; q0 left unlimited
    task automatic t_rates();
        wr(8'h18, 8'hd0);
        wr(8'h19, 8'hfe);
        rd(8'h19, 8'hfe);
        drain(0, 0);
        chk("unlimited", 16'(queue_eligible_o[0][0]), 16'h0001);
        drain(0, 1);
        recover(0, 1, 8);
        drain(0, 2);
        recover(0, 2, 7);
        drain(0, 3);
        recover(0, 3, 6);
        $display("rate test done");
    endtask : t_rates

    // port 1 at 10 Mbps: 16 Mbps lifts, 8 Mbps and 64 kbps still limit
    task automatic t_ten_meg();
        ten_meg_twisted_pair_speed_i[1] = 1'b1;
        wr(8'h28, 8'h89);
        wr(8'h29, 8'h01);
        drain(1, 0);
        chk("ten_meg_q0", 16'(queue_eligible_o[1][0]), 16'h0001);
        drain(1, 1);
        chk("ten_meg_q1", 16'(queue_eligible_o[1][1]), 16'h0000);
        drain(1, 2);
        cyc(900);
        chk("slow_q2", 16'(queue_eligible_o[1][2]), 16'h0000);
        $display("ten meg test done");
    endtask : t_ten_meg

    // port 2 single queue; a code written during a frame waits for it to end
    task automatic t_single();
        multi_queue_en_i = 1'b0;
        wr(8'h38, 8'hf0);
        drain(2, 1);
        chk("single_q", 16'(queue_eligible_o[2]), 16'h000f);
        tx_busy_i[2] = 1'b1;
        wr(8'h38, 8'h0f);
        drain(2, 3);
        chk("busy_hold", 16'(queue_eligible_o[2]), 16'h000f);
        tx_busy_i[2] = 1'b0;
        cyc(2);
        drain(2, 3);
        chk("single_q0", 16'(queue_eligible_o[2]), 16'h000e);
        multi_queue_en_i = 1'b1;
        $display("single queue test done");
    endtask : t_single

    // main sequence
    initial begin
        cyc(4);
        arst_n_i = 1'b1;
        cyc(1);
        t_regs();
        t_rates();
        t_ten_meg();
        t_single();
        give_verdict();
    end

endmodule : egress_rate_limit_tb_top
